// file: hw/dpsl_defs.svh
`ifndef DPSL_DEFS_SVH
`define DPSL_DEFS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DPSL_MODE_ADDR 32'hFFFFE510
`define DPSL_KEY_ADDR 32'hFFFFE514
`define DPSL_STAT_ADDR 32'hFFFFE518

// ----------------------------------------
// fields and values
// ----------------------------------------
`define DPSL_OFF_BIT 0
`define DPSL_OFF_RST 1'b1
`define DPSL_UNLOCK_KEY 32'h000000C5
`define DPSL_STAT_LOCK_BIT 0
`define DPSL_STAT_DENY_BIT 1
`define DPSL_ZERO_WORD 32'h00000000

`endif

// file: hw/dpsl_pkg.sv
package dpsl_pkg;

    // ----------------------------------------
    // probe gate state, one-hot
    // ----------------------------------------
    typedef enum logic [1:0] {
        DPSL_LOCKED = 2'b01,
        DPSL_OPEN = 2'b10
    } dpsl_state_t;

endpackage

// file: hw/dpsl_probe_lock.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "dpsl_defs.svh"

module dpsl_probe_lock
    import dpsl_pkg::*;
(
    input wire logic clock, // system clock, 50 MHz
    input wire logic resetn, // ordinary reset, async, low
    input wire logic por_n, // power-on reset, async, low
    input wire logic [31:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic probe_req, // probe access request pulse
    input wire logic probe_flash_rd, // request is a flash read
    input wire logic [31:0] probe_flash_data, // flash word for the probe
    output logic probe_en, // probe interface usable
    output logic probe_ack, // request granted pulse
    output logic probe_deny, // request refused pulse
    output logic [31:0] probe_rdata // data returned to the probe
);

    // ----------------------------------------
    // reset and decode
    // ----------------------------------------
    // bus side state clears on either reset; lock state only on power-on
    logic any_rst_n;
    assign any_rst_n = resetn & por_n;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    logic wr_mode;
    logic wr_key;
    logic wr_stat;
    logic key_ok;
    // writes are ignored while the ordinary reset is held
    assign wr_mode = wr && resetn && hit(addr, `DPSL_MODE_ADDR);
    assign wr_key = wr && resetn && hit(addr, `DPSL_KEY_ADDR);
    assign wr_stat = wr && resetn && hit(addr, `DPSL_STAT_ADDR);
    assign key_ok = (wdata == `DPSL_UNLOCK_KEY);

    // ----------------------------------------
    // lock mode register
    // ----------------------------------------
    logic probe_off_q;

    always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
            probe_off_q <= `DPSL_OFF_RST;
        end else if (wr_mode) begin
            probe_off_q <= wdata[`DPSL_OFF_BIT];
        end
    end

    // ----------------------------------------
    // gate state
    // ----------------------------------------
    // the mode bit alone does nothing: a runaway write cannot unlock
    dpsl_state_t state_q;
    dpsl_state_t state_d;
    logic locked;

    always_comb begin
        state_d = state_q;
        case (state_q)
            DPSL_LOCKED: begin
                if (wr_key && key_ok && !probe_off_q) begin
                    state_d = DPSL_OPEN;
                end
            end
            DPSL_OPEN: begin
                if (wr_key && key_ok && probe_off_q) begin
                    state_d = DPSL_LOCKED;
                end
            end
            default: begin
                state_d = DPSL_LOCKED;
            end
        endcase
    end

    always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
            state_q <= DPSL_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    assign locked = (state_q != DPSL_OPEN);
    assign probe_en = !locked;

    // ----------------------------------------
    // probe gate
    // ----------------------------------------
    logic probe_ack_q;
    logic probe_deny_q;
    logic [31:0] probe_rdata_q;

    always_ff @(posedge clock or negedge any_rst_n) begin
        if (!any_rst_n) begin
            probe_ack_q <= 1'b0;
            probe_deny_q <= 1'b0;
        end else begin
            probe_ack_q <= probe_req && !locked;
            probe_deny_q <= probe_req && locked;
        end
    end

    always_ff @(posedge clock or negedge any_rst_n) begin
        if (!any_rst_n) begin
            probe_rdata_q <= `DPSL_ZERO_WORD;
        end else if (probe_req) begin
            if (probe_flash_rd && !locked) begin
                probe_rdata_q <= probe_flash_data;
            end else begin
                probe_rdata_q <= `DPSL_ZERO_WORD;
            end
        end
    end

    assign probe_ack = probe_ack_q;
    assign probe_deny = probe_deny_q;
    assign probe_rdata = probe_rdata_q;

    // ----------------------------------------
    // refused-attempt flag
    // ----------------------------------------
    // sticky; a refusal in the clearing cycle survives the clear
    logic denied_q;

    always_ff @(posedge clock or negedge any_rst_n) begin
        if (!any_rst_n) begin
            denied_q <= 1'b0;
        end else if (probe_req && locked) begin
            denied_q <= 1'b1;
        end else if (wr_stat && wdata[`DPSL_STAT_DENY_BIT]) begin
            denied_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // key register is write only and reads zero, as do unmapped words
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = `DPSL_ZERO_WORD;
        if (hit(addr, `DPSL_MODE_ADDR)) begin
            rdata_d[`DPSL_OFF_BIT] = probe_off_q;
        end else if (hit(addr, `DPSL_STAT_ADDR)) begin
            rdata_d[`DPSL_STAT_LOCK_BIT] = locked;
            rdata_d[`DPSL_STAT_DENY_BIT] = denied_q;
        end
    end

    always_ff @(posedge clock or negedge any_rst_n) begin
        if (!any_rst_n) begin
            rdata_q <= `DPSL_ZERO_WORD;
        end else if (rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `DPSL_ZERO_WORD;
        end
    end

    assign rdata = rdata_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!any_rst_n);

    sequence clear_off_s;
        wr && resetn && addr == `DPSL_MODE_ADDR && !wdata[`DPSL_OFF_BIT];
    endsequence

    sequence set_off_s;
        wr && resetn && addr == `DPSL_MODE_ADDR && wdata[`DPSL_OFF_BIT];
    endsequence

    sequence good_key_s;
        wr && resetn && addr == `DPSL_KEY_ADDR && wdata == `DPSL_UNLOCK_KEY;
    endsequence

    sequence bad_key_s;
        wr && resetn && addr == `DPSL_KEY_ADDR && wdata != `DPSL_UNLOCK_KEY;
    endsequence

    locked_denies_a: assert property (
        probe_req && !probe_en |=> probe_deny && !probe_ack
    ) else $error("probe request not refused while locked");

    open_grants_a: assert property (
        probe_req && probe_en |=> probe_ack && !probe_deny
    ) else $error("probe request not granted while open");

    flash_hidden_a: assert property (
        probe_req && probe_flash_rd && !probe_en |=> probe_rdata == `DPSL_ZERO_WORD
    ) else $error("flash data reached probe while locked");

    flash_passed_a: assert property (
        probe_req && probe_flash_rd && probe_en |=> probe_rdata == $past(probe_flash_data)
    ) else $error("flash data lost while open");

    unlock_seq_a: assert property (
        clear_off_s ##1 good_key_s |=> probe_en
    ) else $error("two-step unlock did not open the probe");

    relock_seq_a: assert property (
        set_off_s ##1 good_key_s |=> !probe_en ##1 !probe_en
    ) else $error("two-step relock did not close the probe");

    mode_read_a: assert property (
        rd && addr == `DPSL_MODE_ADDR |=> rdata == {31'b0, $past(probe_off_q)}
    ) else $error("lock mode register read wrong");

    mode_alone_a: assert property (
        wr_mode |=> probe_en == $past(probe_en)
    ) else $error("mode write alone changed the gate");

    mode_kept_a: assert property (
        @(posedge clock) disable iff (!por_n)
        !resetn |=> $stable(probe_off_q) && $stable(state_q)
    ) else $error("ordinary reset disturbed the lock");

    bad_key_a: assert property (
        bad_key_s |=> $stable(probe_en)
    ) else $error("wrong key changed the gate");

    key_reads_zero_a: assert property (
        rd && addr == `DPSL_KEY_ADDR |=> rdata == `DPSL_ZERO_WORD
    ) else $error("key register read not zero");

    // ----------------------------------------
    // status, read port, probe housekeeping, mode write and gate causes
    // ----------------------------------------
    stat_read_a: assert property (
        rd && addr == `DPSL_STAT_ADDR |=> rdata == {30'h0, $past(denied_q), $past(locked)}
    ) else $error("status register read wrong");

    rdata_idle_a: assert property (
        !rd |=> rdata == `DPSL_ZERO_WORD
    ) else $error("read data not zero outside a read");

    ack_deny_excl_a: assert property (
        probe_ack |-> !probe_deny
    ) else $error("probe granted and refused at once");

    probe_quiet_a: assert property (
        !probe_req |=> !probe_ack && !probe_deny
    ) else $error("probe answer without a request");

    probe_data_hold_a: assert property (
        !probe_req |=> $stable(probe_rdata)
    ) else $error("probe data changed without a request");

    plain_req_zero_a: assert property (
        probe_req && !probe_flash_rd |=> probe_rdata == `DPSL_ZERO_WORD
    ) else $error("probe data returned for a non-flash request");

    deny_flag_set_a: assert property (
        probe_req && !probe_en |=> denied_q
    ) else $error("refused request not recorded");

    deny_flag_clear_a: assert property (
        wr_stat && wdata[`DPSL_STAT_DENY_BIT] && !(probe_req && !probe_en) |=> !denied_q
    ) else $error("refused-attempt flag not cleared");

    mode_write_a: assert property (
        wr_mode |=> probe_off_q == $past(wdata[`DPSL_OFF_BIT])
    ) else $error("lock mode write not applied");

    key_only_a: assert property (
        !wr_key |=> $stable(state_q)
    ) else $error("gate moved without a key write");

    open_cause_a: assert property (
        $rose(probe_en) |-> $past(wr_key) && $past(key_ok) && !$past(probe_off_q)
    ) else $error("probe opened without cleared bit and key");

    close_cause_a: assert property (
        $fell(probe_en) |-> $past(wr_key) && $past(key_ok) && $past(probe_off_q)
    ) else $error("probe closed without set bit and key");

endmodule

// file: test/dpsl_probe_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// external probe stand-in
// ----------------------------------------
module dpsl_probe_model (
    input wire logic clock, // system clock
    input wire logic go, // bench asks for one request
    input wire logic flash, // request is a flash read
    input wire logic [31:0] word, // flash word to offer
    output logic probe_req = 1'b0, // request pulse
    output logic probe_flash_rd = 1'b0, // flash read qualifier
    output logic [31:0] probe_flash_data = 32'h00000000 // offered flash word
);
    // between requests the qualifiers toggle so a stale word never looks valid
    always @(posedge clock) begin
        probe_req <= go;
        probe_flash_rd <= go ? flash : ~probe_flash_rd;
        probe_flash_data <= go ? word : ~probe_flash_data;
    end
endmodule

// file: test/dpsl_probe_lock_tb.sv
`timescale 1ns/1ns
`include "dpsl_defs.svh"

module dpsl_probe_lock_tb;
    logic clock = 1'b0, resetn = 1'b1, por_n = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, flash = 1'b0, rd_d = 1'b0;
    logic [31:0] addr = 32'h00000000, wdata = 32'h00000000, word = 32'h00000000, seed = 32'h4BFC6A9A;
    logic [31:0] rdata, probe_flash_data, probe_rdata;
    logic probe_req, probe_flash_rd, probe_en, probe_ack, probe_deny, off_m, open_m;
    logic denied_m = 1'b0, pend_m = 1'b0, en_m = 1'b0;
    logic [31:0] rq[$];
    logic [33:0] pq[$];
    int fails = 0, checks_done = 0;

    initial begin
        forever #10 clock = ~clock;
    end

    dpsl_probe_lock dpsl_probe_lock_inst (.clock(clock), .resetn(resetn), .por_n(por_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .probe_req(probe_req), .probe_flash_rd(probe_flash_rd),
        .probe_flash_data(probe_flash_data), .probe_en(probe_en), .probe_ack(probe_ack),
        .probe_deny(probe_deny), .probe_rdata(probe_rdata));
    dpsl_probe_model dpsl_probe_model_inst (.clock(clock), .go(go), .flash(flash), .word(word),
        .probe_req(probe_req), .probe_flash_rd(probe_flash_rd), .probe_flash_data(probe_flash_data));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic rst(input logic por);
        @(posedge clock);
        resetn <= 1'b0;
        if (por) por_n <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        por_n <= 1'b1;
        denied_m = 1'b0;
        pend_m = 1'b0;
        if (por) begin
            off_m = 1'b1;
            open_m = 1'b0;
            en_m = 1'b0;
        end
    endtask

    // one bus cycle plus an optional probe request; the gate model is updated before the probe
    // expectation because the model delays the request by one edge
    task automatic step(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d,
                        input logic g = 1'b0, input logic f = 1'b0);
        logic [31:0] x;
        x = rnd();
        @(posedge clock);
        en_m = open_m;
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        go <= g;
        flash <= f;
        word <= x;
        if (w && a == `DPSL_MODE_ADDR) off_m = d[0];
        if (w && a == `DPSL_KEY_ADDR && d == `DPSL_UNLOCK_KEY) open_m = !off_m;
        if (r) rq.push_back(a == `DPSL_MODE_ADDR ? {31'h00000000, off_m} :
                            a == `DPSL_STAT_ADDR ? {30'h0, denied_m, !en_m} : 32'h00000000);
        // a clear and a refusal landing on one edge: the refusal wins
        if (w && a == `DPSL_STAT_ADDR && d[1]) denied_m = 1'b0;
        if (pend_m) denied_m = 1'b1;
        pend_m = g && !open_m;
        if (g) pq.push_back({open_m, !open_m, (open_m && f) ? x : 32'h00000000});
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge clock) rd_d <= rd;
    always @(negedge clock) begin
        if (rd_d) check("rdata", rq.size() ? rq.pop_front() : ~rdata, rdata);
        if ((probe_ack | probe_deny) !== 1'b0)
            check("probe", pq.size() ? pq.pop_front() : ~{probe_ack, probe_deny, probe_rdata},
                  {probe_ack, probe_deny, probe_rdata});
        if (por_n) check("probe_en", {33'h0, en_m}, {33'h0, probe_en});
    end

    initial begin
        rst(1'b1);
        step(0, 1, `DPSL_MODE_ADDR, 0);
        step(0, 1, `DPSL_KEY_ADDR, 0, 1, 1);
        step(0, 1, 32'hFFFFE51C, 0, 1, 0);
        step(1, 0, `DPSL_KEY_ADDR, `DPSL_UNLOCK_KEY, 1, 1);
        step(1, 0, `DPSL_MODE_ADDR, 32'hFFFFFFFE, 1, 1);
        step(0, 1, `DPSL_MODE_ADDR, 0, 1, 1);
        step(1, 0, `DPSL_KEY_ADDR, 32'h000000C4, 1, 1);
        step(1, 0, `DPSL_KEY_ADDR, 32'h100000C5, 1, 1);
        step(0, 1, `DPSL_STAT_ADDR, 0);
        step(1, 0, `DPSL_STAT_ADDR, 32'h00000002);
        step(0, 1, `DPSL_STAT_ADDR, 0, 1, 0);
        step(1, 0, `DPSL_STAT_ADDR, 32'h00000002);
        step(0, 1, `DPSL_STAT_ADDR, 0);
        step(1, 0, `DPSL_KEY_ADDR, `DPSL_UNLOCK_KEY, 1, 1);
        repeat (8) step(0, 0, 0, 0, 1, 1'(rnd()));
        step(0, 1, `DPSL_STAT_ADDR, 0);
        repeat (2) step(0, 0, 0, 0);
        rst(1'b0);
        step(0, 1, `DPSL_STAT_ADDR, 0);
        step(0, 1, `DPSL_MODE_ADDR, 0, 1, 1);
        step(1, 0, `DPSL_MODE_ADDR, 32'h00000001, 1, 1);
        step(1, 0, `DPSL_KEY_ADDR, `DPSL_UNLOCK_KEY, 1, 1);
        step(0, 1, `DPSL_MODE_ADDR, 0, 1, 1);
        repeat (2) step(0, 0, 0, 0);
        rst(1'b1);
        step(0, 1, `DPSL_MODE_ADDR, 0, 1, 1);
        step(0, 0, 0, 0);
        for (int i = 0; i < 10 && (rq.size() + pq.size()) > 0; i++) @(posedge clock);
        if ((rq.size() + pq.size()) > 0) begin
            fails++;
            $display("[ERR] pending results expected 0 seen %0d", rq.size() + pq.size());
        end
        summarize();
    end
endmodule
